// ---- pkg/crc_pkg.sv ----
package crc_pkg;
  // Core clock and low-frequency tick
  localparam int CORE_CLK_HZ = 25000000;
  localparam int LF_DIV_DEFAULT = 8;
  // Filter timing in microseconds
  localparam int RST_MIN_US = 1500;
  localparam int RST_MAX_US = 4000;
  // Filter: 2000 us of steady low, counted in core cycles
  localparam int FILT_US = 2000;
  localparam int FILT_CYC = FILT_US * (CORE_CLK_HZ / 1000000);
  localparam int SYNC_STAGES = 2;
  // Reset value of the crystal frequency code: highest allowed
  localparam logic [3:0] XTAL_MAX_CODE = 4'hF;
  localparam logic [1:0] RATE_RESET = 2'h0;
  // Weak pull patterns: 1 means pull-up
  localparam logic [7:0] SER_PULL_UP = 8'h2E;
  localparam logic [15:0] GPIO_PULL_UP = 16'h0000;
  localparam int N_SER = 8;
  localparam int N_GPIO = 16;
endpackage

// ---- rtl/crc_reset_ctrl.sv ----
`timescale 1ns/10ps
module crc_reset_ctrl
  import crc_pkg::*;
#(
  parameter int LF_DIV = LF_DIV_DEFAULT,
  parameter int FILT_CYCLES = FILT_CYC
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic RST_N_I,
  input wire logic VDD_LOW_I,
  input wire logic VDD_OK_I,
  input wire logic UART_BREAK_I,
  input wire logic WDOG_EXPIRE_I,
  input wire logic XTAL_PRESENT_I,
  input wire logic XTAL_CFG_VALID_I,
  input wire logic [3:0] XTAL_CFG_I,
  output logic CHIP_RESET_O,
  output logic POR_O,
  output logic PAD_OE_N_O,
  output logic [N_SER-1:0] SER_PULL_UP_O,
  output logic [N_SER-1:0] SER_PULL_EN_O,
  output logic [N_GPIO-1:0] GPIO_PULL_UP_O,
  output logic [N_GPIO-1:0] GPIO_PULL_EN_O,
  output logic [3:0] XTAL_CODE_O,
  output logic SLOW_CLK_MODE_O,
  output logic OSC_FREE_RUN_O,
  output logic WARM_RESET_O,
  output logic STATE_VALID_O
);

  localparam int LFW = $clog2(LF_DIV + 1);
  localparam int FW = $clog2(FILT_CYCLES + 1);

  logic [LFW-1:0] lf_cnt_ff;
  logic lf_tick_ff;
  logic [SYNC_STAGES-1:0] pin_sync_ff;
  logic [FW-1:0] filt_cnt_ff;
  logic pin_rst_ff;
  logic por_ff;
  logic any_src;
  logic rst_hold_ff;
  logic cold_ff;

  // ----------------------------------------------------------------
  // Slow clock tick
  // ----------------------------------------------------------------
  // Divider standing in for the low-frequency oscillator
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      lf_cnt_ff <= '0;
      lf_tick_ff <= 1'b0;
    end else if (lf_cnt_ff == LFW'(LF_DIV - 1)) begin
      lf_cnt_ff <= '0;
      lf_tick_ff <= 1'b1;
    end else begin
      lf_cnt_ff <= lf_cnt_ff + 1'b1;
      lf_tick_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin filter
  // ----------------------------------------------------------------
  // Pin sampled on slow ticks only, so glitches are missed
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pin_sync_ff <= '1;
    end else if (lf_tick_ff) begin
      pin_sync_ff <= {pin_sync_ff[SYNC_STAGES-2:0], RST_N_I};
    end
  end

  // Count core cycles of steady low; 2 ms sits inside 1.5..4.0 ms
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      filt_cnt_ff <= '0;
      pin_rst_ff <= 1'b0;
    end else if (pin_sync_ff[SYNC_STAGES-1]) begin
      filt_cnt_ff <= '0;
      pin_rst_ff <= 1'b0;
    end else if (filt_cnt_ff >= FW'(FILT_CYCLES)) begin
      pin_rst_ff <= 1'b1;
    end else begin
      filt_cnt_ff <= filt_cnt_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Power-on detector with hysteresis
  // ----------------------------------------------------------------
  // Low trips below the falling level, ok above the rising level
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      por_ff <= 1'b1;
    end else if (VDD_LOW_I) begin
      por_ff <= 1'b1;
    end else if (VDD_OK_I) begin
      por_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Combined reset
  // ----------------------------------------------------------------
  assign any_src = pin_rst_ff | por_ff | UART_BREAK_I | WDOG_EXPIRE_I;

  // Assert at once, release only on a slow tick
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rst_hold_ff <= 1'b1;
    end else if (any_src) begin
      rst_hold_ff <= 1'b1;
    end else if (lf_tick_ff) begin
      rst_hold_ff <= 1'b0;
    end
  end

  // Cold when the supply dropped; kept until the next pin, break or watchdog reset
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cold_ff <= 1'b1;
    end else if (por_ff) begin
      cold_ff <= 1'b1;
    end else if (any_src) begin
      cold_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Pads: inputs or high-z with weak pulls while in reset
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      CHIP_RESET_O <= 1'b1;
      POR_O <= 1'b1;
      PAD_OE_N_O <= 1'b1;
      SER_PULL_UP_O <= SER_PULL_UP;
      SER_PULL_EN_O <= '1;
      GPIO_PULL_UP_O <= GPIO_PULL_UP;
      GPIO_PULL_EN_O <= '1;
    end else begin
      CHIP_RESET_O <= rst_hold_ff | any_src;
      POR_O <= por_ff;
      PAD_OE_N_O <= rst_hold_ff | any_src | PAD_OE_N_O & ~lf_tick_ff;
      SER_PULL_UP_O <= SER_PULL_UP;
      SER_PULL_EN_O <= {N_SER{rst_hold_ff | any_src}};
      GPIO_PULL_UP_O <= GPIO_PULL_UP;
      GPIO_PULL_EN_O <= {N_GPIO{rst_hold_ff | any_src}};
    end
  end

  // Clock plan: top crystal code until software configures it
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      XTAL_CODE_O <= XTAL_MAX_CODE;
      SLOW_CLK_MODE_O <= 1'b1;
      OSC_FREE_RUN_O <= 1'b1;
    end else begin
      OSC_FREE_RUN_O <= ~XTAL_PRESENT_I;
      if (rst_hold_ff | any_src) begin
        XTAL_CODE_O <= XTAL_MAX_CODE;
        SLOW_CLK_MODE_O <= 1'b1;
      end else if (XTAL_CFG_VALID_I) begin
        XTAL_CODE_O <= XTAL_CFG_I;
        SLOW_CLK_MODE_O <= 1'b0;
      end
    end
  end

  // Warm flag tells software the rate and RAM may be trusted
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      WARM_RESET_O <= 1'b0;
      STATE_VALID_O <= 1'b0;
    end else begin
      WARM_RESET_O <= ~cold_ff;
      STATE_VALID_O <= ~cold_ff & ~rst_hold_ff;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_source_resets: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    (UART_BREAK_I | WDOG_EXPIRE_I) |=> CHIP_RESET_O)
    else $error("source did not reset");
  a_pin_filtered: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    $rose(pin_rst_ff) |-> !$past(pin_sync_ff[SYNC_STAGES-1]))
    else $error("pin reset without low pin");
  a_pin_delay: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    $rose(pin_rst_ff) |-> filt_cnt_ff == FW'(FILT_CYCLES))
    else $error("pin reset delay wrong");
  a_por_hyst: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    VDD_LOW_I |=> por_ff ##1 POR_O)
    else $error("power-on reset missed");
  a_pads_safe: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    CHIP_RESET_O |-> PAD_OE_N_O && (&SER_PULL_EN_O))
    else $error("pads driven in reset");
  a_xtal_max: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    CHIP_RESET_O |-> XTAL_CODE_O == XTAL_MAX_CODE && SLOW_CLK_MODE_O)
    else $error("crystal code not max");
  a_osc_free: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    !XTAL_PRESENT_I |=> OSC_FREE_RUN_O)
    else $error("oscillator not free-running");
  a_pull_dirs: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    SER_PULL_UP_O == SER_PULL_UP && GPIO_PULL_UP_O == GPIO_PULL_UP)
    else $error("pull direction wrong");
  a_cold_state: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    por_ff |=> ##1 !STATE_VALID_O && !WARM_RESET_O)
    else $error("cold reset kept state");
  a_release_tick: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    $fell(rst_hold_ff) |-> $past(lf_tick_ff) && !$past(any_src))
    else $error("release off slow tick");
  c_pin_reset: cover property (@(posedge CORE_CLK_I) $rose(pin_rst_ff));
  c_warm: cover property (@(posedge CORE_CLK_I) $rose(WARM_RESET_O));
  c_xtal_cfg: cover property (@(posedge CORE_CLK_I) $fell(SLOW_CLK_MODE_O));
endmodule

// ---- tb/crc_supply_model.sv ----
`timescale 1ns/10ps
// Reset pin driver and core supply monitor
module crc_supply_model #(
  parameter int RAMP = 4
) (
  input wire logic clk_i,
  input wire logic pin_hold_i,
  input wire logic vdd_down_i,
  output logic rst_n_o,
  output logic vdd_low_o,
  output logic vdd_ok_o
);
  int ramp_ff = 0;
  // Released pin floats to its pull-up
  assign rst_n_o = !pin_hold_i;
  // Supply dwells between thresholds while it ramps up
  assign vdd_low_o = vdd_down_i;
  assign vdd_ok_o = ramp_ff >= RAMP;
  always_ff @(posedge clk_i) begin
    if (vdd_down_i) begin
      ramp_ff <= 0;
    end else if (ramp_ff < RAMP) begin
      ramp_ff <= ramp_ff + 1;
    end
  end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
  import crc_pkg::*;
  logic clk = 0, rst = 1, hold = 0, down = 1, brk = 0, wdg = 0;
  logic xp = 1, cv = 0, rst_n, vlo, vok, chip, por, oe_n;
  logic slow, frun, warm, valid;
  logic [3:0] cfg = 4'h0, code;
  logic [7:0] spu, spe;
  logic [15:0] gpu, gpe;
  int mismatches = 0, n_tests = 0, n;
  // 25 MHz core clock
  always #20 clk = ~clk;
  crc_supply_model #(.RAMP(4)) PM (.clk_i(clk), .pin_hold_i(hold),
    .vdd_down_i(down), .rst_n_o(rst_n), .vdd_low_o(vlo), .vdd_ok_o(vok));
  // Short counts: filter 20 cycles stands for 2 ms
  crc_reset_ctrl #(.LF_DIV(2), .FILT_CYCLES(20)) DUT (.CORE_CLK_I(clk),
    .RESET_I(rst), .RST_N_I(rst_n), .VDD_LOW_I(vlo), .VDD_OK_I(vok),
    .UART_BREAK_I(brk), .WDOG_EXPIRE_I(wdg), .XTAL_PRESENT_I(xp),
    .XTAL_CFG_VALID_I(cv), .XTAL_CFG_I(cfg), .CHIP_RESET_O(chip),
    .POR_O(por), .PAD_OE_N_O(oe_n), .SER_PULL_UP_O(spu),
    .SER_PULL_EN_O(spe), .GPIO_PULL_UP_O(gpu), .GPIO_PULL_EN_O(gpe),
    .XTAL_CODE_O(code), .SLOW_CLK_MODE_O(slow), .OSC_FREE_RUN_O(frun),
    .WARM_RESET_O(warm), .STATE_VALID_O(valid));
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string s, logic [23:0] e, logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  // Bounded wait on the chip reset; a hang ends the run
  task automatic wait_rst(logic v, int lim);
    for (n = 1; n <= lim; n++) begin
      @(negedge clk);
      if (chip === v) break;
    end
    if (chip !== v) begin
      mismatches++;
      $display("mismatch chip_reset exp %h got %h", v, chip);
      results();
    end
  endtask
  task automatic t_defaults();
    @(negedge clk);
    chk("por", 1, por);
    chk("oe_n", 1, oe_n);
    chk("ser_up", SER_PULL_UP, spu);
    chk("pulls", 24'hFFFFFF, {spe, gpe});
    chk("gpio_up", GPIO_PULL_UP, gpu);
    chk("code", XTAL_MAX_CODE, code);
    chk("slow", 1, slow);
  endtask
  // Supply ramps through the hysteresis band, then reset lifts
  task automatic t_power();
    @(posedge clk) down <= 0;
    @(negedge clk);
    chk("por_band", 1, por);
    wait_rst(0, 40);
    chk("por_off", 0, por);
    chk("cold", 2'h0, {warm, valid});
  endtask
  task automatic t_xtal();
    @(posedge clk) xp <= 0;
    repeat (3) @(negedge clk);
    chk("free_run", 1, frun);
    @(posedge clk) begin xp <= 1; cv <= 1; cfg <= 4'h5; end
    repeat (3) @(negedge clk);
    chk("free_off", 0, frun);
    chk("cfg", 5'h05, {slow, code});
    @(posedge clk) cv <= 0;
  endtask
  // One-cycle break or watchdog pulse gives a warm reset
  task automatic t_soft(bit w);
    @(posedge clk) if (w) wdg <= 1; else brk <= 1;
    @(posedge clk) begin wdg <= 0; brk <= 0; end
    @(negedge clk);
    chk("soft_rst", 1, chip);
    chk("soft_oe", 1, oe_n);
    chk("soft_clk", 5'h1F, {slow, code});
    wait_rst(0, 20);
    chk("warm", 2'h3, {warm, valid});
    chk("soft_pulls", 24'h0, {spe, gpe});
    repeat (2) @(negedge clk);
    chk("soft_oe_off", 0, oe_n);
  endtask
  // Short pin glitch ignored; long hold taken in 15..40 cycles
  // One cycle stands for 100 us at the short filter count
  task automatic t_pin();
    @(posedge clk) hold <= 1;
    repeat (10) @(posedge clk);
    hold <= 0;
    repeat (40) @(negedge clk) chk("glitch", 0, chip);
    @(posedge clk) hold <= 1;
    wait_rst(1, 60);
    chk("pin_delay", 1, n >= RST_MIN_US / 100 && n <= RST_MAX_US / 100);
    // Pin kept low past 50 cycles, the scaled 5 ms
    repeat (26) @(posedge clk);
    hold <= 0;
    wait_rst(0, 20);
    chk("pin_warm", 1, warm);
  endtask
  task automatic t_drop();
    @(posedge clk) down <= 1;
    repeat (3) @(negedge clk);
    chk("drop", 2'h3, {por, chip});
    t_power();
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    t_defaults();
    t_power();
    t_xtal();
    t_soft(0);
    t_soft(1);
    t_pin();
    t_drop();
    results();
  end
endmodule
